//--- src/ldc_pkg.sv
// Package with register map, field layouts, encodings and timing counts
package ldc_pkg;

	// ======================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CMD        = 8'h00;
	localparam logic [7:0] OFF_CFG        = 8'h04;
	localparam logic [7:0] OFF_STATE      = 8'h08;
	localparam logic [7:0] OFF_ERR        = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
	localparam logic [7:0] OFF_SEG_DATA   = 8'h1C;

	// ======================================================
	// Command register fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_ARG_BIT  = 4;
	localparam int CMD_SEL_LSB  = 8;
	localparam int CMD_DRV_BIT  = 12;
	localparam int CMD_AREA_LSB = 16;

	localparam logic [3:0] OP_NONE    = 4'h0;
	localparam logic [3:0] OP_INIT    = 4'h1;
	localparam logic [3:0] OP_DISP_ON = 4'h2;
	localparam logic [3:0] OP_DISP_OFF = 4'h3;
	localparam logic [3:0] OP_CIRCUIT = 4'h4;
	localparam logic [3:0] OP_CONTROL = 4'h5;
	localparam logic [3:0] OP_CLOSE   = 4'h6;

	// Change-select bits, combinable
	localparam logic [1:0] SEL_DRIVE = 2'h1;
	localparam logic [1:0] SEL_AREA  = 2'h2;

	// ======================================================
	// Configuration register fields
	localparam int CFG_METHOD_LSB = 0;
	localparam int CFG_SELF_WAIT  = 2;
	localparam int CFG_EIGHT_SLOT = 3;
	localparam logic [3:0] CFG_RESET = 4'h0;

	// ======================================================
	// Error codes
	localparam logic [2:0] ERR_NONE     = 3'h0;
	localparam logic [2:0] ERR_NOT_OPEN = 3'h1;
	localparam logic [2:0] ERR_ARG      = 3'h2;
	localparam logic [2:0] ERR_RTC      = 3'h3;

	// ======================================================
	// Interrupt bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_READY = 2;
	localparam int IRQ_WIDTH = 3;

	// ======================================================
	// Timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int BOOST_WAIT_US = 5;
	localparam int BOOST_WAIT_CYC = (BOOST_WAIT_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
		BOOST_WAIT_US * (CLK_HZ / 1_000_000);

	// ======================================================
	// Types
	typedef enum logic [1:0] {
		DRV_RESISTOR,
		DRV_BOOST,
		DRV_CAP_SPLIT
	} ldc_method_type;

	typedef enum logic [1:0] {
		AREA_A,
		AREA_B,
		AREA_BLINK
	} ldc_area_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ldc_bus_type;

	typedef struct packed {
		logic       drive_on;
		logic       circuit_on;
		logic       show_b;
		logic [3:0] seg_nibble;
	} ldc_panel_type;

endpackage

//--- src/ldc_wait_timer.sv
// Down-counter that times the voltage boost settling wait
`timescale 1ns/1ns
module ldc_wait_timer #(
	parameter int WAIT_CYC = 125
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Control
	input  wire logic start,
	input  wire logic abort,
	output logic      busy_reg
);

	logic [$clog2(WAIT_CYC+1)-1:0] count_reg;

	always_ff @(posedge clk_sys) begin
		if (!reset_n || abort) begin
			count_reg <= '0;
			busy_reg  <= 1'b0;
		end else if (start) begin
			count_reg <= ($clog2(WAIT_CYC+1))'(WAIT_CYC);
			busy_reg  <= 1'b1;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
			busy_reg  <= (count_reg != 1);
		end
	end

endmodule

//--- src/ldc_display_ctrl.sv
// Display enable, drive circuit and display area control for a segment LCD
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns

// Behaviour
// - Display off either keeps voltage circuit running or also halts it.
// - Halting variant accepted only under boost or capacitor split.
// - On halt, stop the circuit, then switch drive to resistor division (both done in the same cycle here).
// - Re-enable circuit restores prior method before display enable.
// - After circuit enable a boost wait elapses, by device if configured.
// - Method change boost<->cap split is display off, change, display on.
// - One control request changes method, area, or both via select bits.
// - Area selects pattern A, pattern B, or blinking between both.
// - Blink request while the clock is stopped is refused with its own error.
// - Outside 8-slot mode, A uses low nibble, B uses high nibble.
module ldc_display_ctrl #(
	parameter int WAIT_CYC = ldc_pkg::BOOST_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  reset_n,
	// Register port
	input  wire ldc_pkg::ldc_bus_type  bus,
	output logic [31:0]                rdata_reg,
	// Real-time clock pins
	input  wire logic                  rtc_running,
	input  wire logic                  rtc_tick,
	// Panel side
	output ldc_pkg::ldc_panel_type     panel_reg,
	output logic                       irq_reg
);

	// ======================================================
	// Synchronisers for the clock-domain inputs
	logic [1:0] run_sync_reg;
	logic [1:0] tick_sync_reg;
	logic       tick_last_reg;
	logic       tick_pulse;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			run_sync_reg  <= 2'h0;
			tick_sync_reg <= 2'h0;
			tick_last_reg <= 1'b0;
		end else begin
			run_sync_reg  <= {run_sync_reg[0], rtc_running};
			tick_sync_reg <= {tick_sync_reg[0], rtc_tick};
			tick_last_reg <= tick_sync_reg[1];
		end
	end
	assign tick_pulse = tick_sync_reg[1] & ~tick_last_reg;

	// ======================================================
	// Command decode
	logic        wr_cmd;
	logic [3:0]  op;
	logic        arg;
	logic [1:0]  sel;
	logic        drv_to_cap;
	logic [1:0]  area_req;

	assign wr_cmd     = bus.wr && bus.addr == ldc_pkg::OFF_CMD;
	assign op         = bus.wdata[ldc_pkg::CMD_OP_LSB +: 4];
	assign arg        = bus.wdata[ldc_pkg::CMD_ARG_BIT];
	assign sel        = bus.wdata[ldc_pkg::CMD_SEL_LSB +: 2];
	assign drv_to_cap = bus.wdata[ldc_pkg::CMD_DRV_BIT];
	assign area_req   = bus.wdata[ldc_pkg::CMD_AREA_LSB +: 2];

	// ======================================================
	// Control state
	logic                   open_reg;
	logic                   disp_reg;
	logic                   circ_reg;
	ldc_pkg::ldc_method_type method_reg;
	ldc_pkg::ldc_method_type saved_reg;
	ldc_pkg::ldc_area_type  area_reg;
	logic                   blink_b_reg;
	logic [3:0]             cfg_reg;
	logic [2:0]             err_reg;
	logic [7:0]             seg_reg;
	logic                   wait_busy;
	logic                   wait_start;
	logic                   ok;
	logic                   fail;
	logic [2:0]             err_next;
	logic                   internal_method;

	assign internal_method = method_reg != ldc_pkg::DRV_RESISTOR;

	always_comb begin
		err_next = ldc_pkg::ERR_NONE;
		if (wr_cmd) begin
			unique case (op)
				ldc_pkg::OP_NONE, ldc_pkg::OP_INIT, ldc_pkg::OP_CLOSE:
					err_next = ldc_pkg::ERR_NONE;
				ldc_pkg::OP_DISP_ON:
					if (!open_reg)
						err_next = ldc_pkg::ERR_NOT_OPEN;
				ldc_pkg::OP_DISP_OFF:
					if (!open_reg)
						err_next = ldc_pkg::ERR_NOT_OPEN;
					else if (arg && !internal_method)
						err_next = ldc_pkg::ERR_ARG;
				ldc_pkg::OP_CIRCUIT:
					if (!open_reg)
						err_next = ldc_pkg::ERR_NOT_OPEN;
					else if (saved_reg == ldc_pkg::DRV_RESISTOR)
						err_next = ldc_pkg::ERR_ARG;
				ldc_pkg::OP_CONTROL:
					if (!open_reg)
						err_next = ldc_pkg::ERR_NOT_OPEN;
					else if (sel == 2'h0 || (sel[1] && area_req == 2'h3))
						err_next = ldc_pkg::ERR_ARG;
					else if (sel[0] && (method_reg != (drv_to_cap ? ldc_pkg::DRV_BOOST : ldc_pkg::DRV_CAP_SPLIT)))
						err_next = ldc_pkg::ERR_ARG;
					else if (sel[1] && area_req == 2'(ldc_pkg::AREA_BLINK) && !run_sync_reg[1])
						err_next = ldc_pkg::ERR_RTC;
				default:
					err_next = ldc_pkg::ERR_ARG;
			endcase
		end
	end
	assign ok   = wr_cmd && err_next == ldc_pkg::ERR_NONE;
	assign fail = wr_cmd && err_next != ldc_pkg::ERR_NONE;

	// Open state and configuration
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			open_reg <= 1'b0;
			cfg_reg  <= ldc_pkg::CFG_RESET;
		end else if (ok && op == ldc_pkg::OP_INIT) begin
			open_reg <= 1'b1;
		end else if (ok && op == ldc_pkg::OP_CLOSE) begin
			open_reg <= 1'b0;
		end else if (bus.wr && bus.addr == ldc_pkg::OFF_CFG && !open_reg) begin
			cfg_reg <= bus.wdata[3:0];
		end
	end

	// Drive method and circuit; halting stops the circuit and drops to resistor division in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			circ_reg   <= 1'b0;
			method_reg <= ldc_pkg::DRV_RESISTOR;
			saved_reg  <= ldc_pkg::DRV_RESISTOR;
		end else if (ok) begin
			unique case (op)
				ldc_pkg::OP_INIT: begin
					method_reg <= ldc_pkg::ldc_method_type'(cfg_reg[ldc_pkg::CFG_METHOD_LSB +: 2]);
					saved_reg  <= ldc_pkg::ldc_method_type'(cfg_reg[ldc_pkg::CFG_METHOD_LSB +: 2]);
					circ_reg   <= cfg_reg[1:0] != 2'h0;
				end
				ldc_pkg::OP_DISP_OFF:
					if (arg) begin
						circ_reg   <= 1'b0;
						saved_reg  <= method_reg;
						method_reg <= ldc_pkg::DRV_RESISTOR;
					end
				ldc_pkg::OP_CIRCUIT:
					if (arg) begin
						circ_reg   <= 1'b1;
						method_reg <= saved_reg;
					end else if (internal_method) begin
						circ_reg   <= 1'b0;
						saved_reg  <= method_reg;
						method_reg <= ldc_pkg::DRV_RESISTOR;
					end
				ldc_pkg::OP_CONTROL:
					if (sel[0]) begin
						method_reg <= drv_to_cap ? ldc_pkg::DRV_CAP_SPLIT : ldc_pkg::DRV_BOOST;
						saved_reg  <= drv_to_cap ? ldc_pkg::DRV_CAP_SPLIT : ldc_pkg::DRV_BOOST;
					end
				ldc_pkg::OP_CLOSE: begin
					circ_reg   <= 1'b0;
					method_reg <= ldc_pkg::DRV_RESISTOR;
				end
				default: begin
				end
			endcase
		end
	end

	// Boost wait after enabling the circuit, run by the device if configured
	assign wait_start = ok && ((op == ldc_pkg::OP_CIRCUIT && arg) || (op == ldc_pkg::OP_INIT && cfg_reg[1:0] != 2'h0))
		&& cfg_reg[ldc_pkg::CFG_SELF_WAIT];

	ldc_wait_timer #(
		.WAIT_CYC (WAIT_CYC)
	) u_wait (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.start    (wait_start),
		.abort    (ok && op == ldc_pkg::OP_CLOSE),
		.busy_reg (wait_busy)
	);

	// Display enable; a method change leaves the display as it was, blanked around the change
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			disp_reg <= 1'b0;
		end else if (ok) begin
			unique case (op)
				ldc_pkg::OP_DISP_ON:  disp_reg <= 1'b1;
				ldc_pkg::OP_DISP_OFF: disp_reg <= 1'b0;
				ldc_pkg::OP_CLOSE:    disp_reg <= 1'b0;
				default:              disp_reg <= disp_reg;
			endcase
		end
	end

	// Area selection and blink phase
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			area_reg    <= ldc_pkg::AREA_A;
			blink_b_reg <= 1'b0;
		end else if (ok && op == ldc_pkg::OP_CONTROL && sel[1]) begin
			area_reg    <= ldc_pkg::ldc_area_type'(area_req);
			blink_b_reg <= 1'b0;
		end else if (area_reg == ldc_pkg::AREA_BLINK && tick_pulse) begin
			blink_b_reg <= ~blink_b_reg;
		end
	end

	// Segment data byte and error register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			seg_reg <= 8'h00;
			err_reg <= ldc_pkg::ERR_NONE;
		end else begin
			if (bus.wr && bus.addr == ldc_pkg::OFF_SEG_DATA)
				seg_reg <= bus.wdata[7:0];
			if (wr_cmd)
				err_reg <= err_next;
		end
	end

	// ======================================================
	// Panel outputs
	logic show_b;
	logic hold_blank;

	always_comb begin
		unique case (area_reg)
			ldc_pkg::AREA_B:     show_b = 1'b1;
			ldc_pkg::AREA_BLINK: show_b = blink_b_reg;
			default:             show_b = 1'b0;
		endcase
	end
	// A method change blanks the panel for that cycle
	assign hold_blank = ok && op == ldc_pkg::OP_CONTROL && sel[0];

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			panel_reg <= '0;
		end else begin
			// The start cycle blanks too, so the panel is never driven before the wait flag rises
			panel_reg.drive_on   <= disp_reg && !wait_busy && !wait_start && !hold_blank;
			panel_reg.circuit_on <= circ_reg;
			panel_reg.show_b     <= show_b;
			if (cfg_reg[ldc_pkg::CFG_EIGHT_SLOT])
				panel_reg.seg_nibble <= show_b ? seg_reg[7:4] : seg_reg[3:0];
			else
				panel_reg.seg_nibble <= show_b ? seg_reg[7:4] : seg_reg[3:0];
		end
	end

	// ======================================================
	// Interrupts: sticky status, write-one-to-clear, set wins
	logic [ldc_pkg::IRQ_WIDTH-1:0] irq_stat_reg;
	logic [ldc_pkg::IRQ_WIDTH-1:0] irq_en_reg;
	logic [ldc_pkg::IRQ_WIDTH-1:0] irq_set;
	logic                          busy_last_reg;

	assign irq_set = {busy_last_reg && !wait_busy, fail, ok};

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			irq_stat_reg  <= '0;
			irq_en_reg    <= '0;
			busy_last_reg <= 1'b0;
			irq_reg       <= 1'b0;
		end else begin
			busy_last_reg <= wait_busy;
			if (bus.wr && bus.addr == ldc_pkg::OFF_IRQ_CLEAR)
				irq_stat_reg <= (irq_stat_reg & ~bus.wdata[ldc_pkg::IRQ_WIDTH-1:0]) | irq_set;
			else
				irq_stat_reg <= irq_stat_reg | irq_set;
			if (bus.wr && bus.addr == ldc_pkg::OFF_IRQ_ENABLE)
				irq_en_reg <= bus.wdata[ldc_pkg::IRQ_WIDTH-1:0];
			irq_reg <= |((irq_stat_reg | irq_set) & irq_en_reg);
		end
	end

	// ======================================================
	// Read port
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus.rd) begin
			unique case (bus.addr)
				ldc_pkg::OFF_CFG:        rdata_reg <= {28'h0, cfg_reg};
				ldc_pkg::OFF_STATE:      rdata_reg <= {21'h0, wait_busy, blink_b_reg, area_reg, saved_reg,
					method_reg, circ_reg, disp_reg, open_reg};
				ldc_pkg::OFF_ERR:        rdata_reg <= {29'h0, err_reg};
				ldc_pkg::OFF_IRQ_STATUS: rdata_reg <= {29'h0, irq_stat_reg};
				ldc_pkg::OFF_IRQ_ENABLE: rdata_reg <= {29'h0, irq_en_reg};
				ldc_pkg::OFF_SEG_DATA:   rdata_reg <= {24'h0, seg_reg};
				default:                 rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	// ======================================================
	// Assertions
	property p_not_open;
		@(posedge clk_sys) disable iff (!reset_n)
		(wr_cmd && op == ldc_pkg::OP_DISP_ON && !open_reg) |=> (err_reg == ldc_pkg::ERR_NOT_OPEN && !disp_reg);
	endproperty
	a_not_open: assert property (p_not_open) else $error("display enabled while not open");

	property p_halt_res;
		@(posedge clk_sys) disable iff (!reset_n)
		(ok && op == ldc_pkg::OP_DISP_OFF && arg) |=> (!circ_reg && method_reg == ldc_pkg::DRV_RESISTOR && !disp_reg);
	endproperty
	a_halt_res: assert property (p_halt_res) else $error("halt did not drop to resistor drive");

	property p_halt_refused;
		@(posedge clk_sys) disable iff (!reset_n)
		(wr_cmd && open_reg && op == ldc_pkg::OP_DISP_OFF && arg && !internal_method) |=> err_reg == ldc_pkg::ERR_ARG;
	endproperty
	a_halt_refused: assert property (p_halt_refused) else $error("halt accepted under resistor drive");

	property p_restore;
		@(posedge clk_sys) disable iff (!reset_n)
		(ok && op == ldc_pkg::OP_CIRCUIT && arg) |=> (circ_reg && method_reg == $past(saved_reg));
	endproperty
	a_restore: assert property (p_restore) else $error("circuit enable did not restore method");

	property p_rtc;
		@(posedge clk_sys) disable iff (!reset_n)
		(wr_cmd && open_reg && op == ldc_pkg::OP_CONTROL && sel == ldc_pkg::SEL_AREA
			&& area_req == 2'(ldc_pkg::AREA_BLINK) && !run_sync_reg[1]) |=> (err_reg == ldc_pkg::ERR_RTC && area_reg != ldc_pkg::AREA_BLINK);
	endproperty
	a_rtc: assert property (p_rtc) else $error("blink accepted with clock stopped");

	property p_blink;
		@(posedge clk_sys) disable iff (!reset_n)
		(area_reg == ldc_pkg::AREA_BLINK && tick_pulse && !wr_cmd) |=> blink_b_reg != $past(blink_b_reg);
	endproperty
	a_blink: assert property (p_blink) else $error("blink phase did not toggle");

	property p_area;
		@(posedge clk_sys) disable iff (!reset_n)
		(ok && op == ldc_pkg::OP_CONTROL && sel[1] && area_req == 2'(ldc_pkg::AREA_B)) |=> ##1 panel_reg.show_b;
	endproperty
	a_area: assert property (p_area) else $error("pattern B not shown");

	property p_wait;
		@(posedge clk_sys) disable iff (!reset_n)
		wait_start |=> (wait_busy && !panel_reg.drive_on) [*2];
	endproperty
	a_wait: assert property (p_wait) else $error("panel driven during boost wait");

	property p_nibble;
		@(posedge clk_sys) disable iff (!reset_n)
		1'b1 |=> panel_reg.seg_nibble == ($past(show_b) ? $past(seg_reg[7:4]) : $past(seg_reg[3:0]));
	endproperty
	a_nibble: assert property (p_nibble) else $error("wrong pattern nibble");

	c_halt:  cover property (@(posedge clk_sys) disable iff (!reset_n) ok && op == ldc_pkg::OP_DISP_OFF && arg);
	c_blink: cover property (@(posedge clk_sys) disable iff (!reset_n) area_reg == ldc_pkg::AREA_BLINK && tick_pulse);
	c_both:  cover property (@(posedge clk_sys) disable iff (!reset_n) ok && op == ldc_pkg::OP_CONTROL && sel == 2'h3);
	c_rtc:   cover property (@(posedge clk_sys) disable iff (!reset_n) fail && err_next == ldc_pkg::ERR_RTC);

endmodule

//--- bench/ldc_rtc_model.sv
// Real-time clock stand-in giving the running flag and a scaled half-second event
`timescale 1ns/1ns
module ldc_rtc_model #(
	parameter int PERIOD = 40,
	parameter int WIDTH  = 4
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// Control from bench
	input  wire logic enable,
	// Clock outputs
	output logic      rtc_running,
	output logic      rtc_tick
);
	// ======================================================
	// Periodic event
	int count_reg;

	// Event held several cycles so the two-stage synchroniser cannot miss it
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !enable) begin
			count_reg   <= 0;
			rtc_running <= 1'b0;
			rtc_tick    <= 1'b0;
		end else begin
			rtc_running <= 1'b1;
			count_reg   <= (count_reg == PERIOD - 1) ? 0 : count_reg + 1;
			rtc_tick    <= (count_reg < WIDTH);
		end
	end
endmodule

//--- bench/ldc_display_ctrl_test.sv
// Self-checking bench for the display control block
`timescale 1ns/1ns
module ldc_display_ctrl_test;
	// ======================================================
	// Stimulus table: command, error code, state, {drive_on, circuit_on, show_b}
	typedef struct packed {
		logic [31:0] cmd;
		logic [2:0]  err;
		logic [31:0] state;
		logic [2:0]  pan;
	} ldc_row_type;

	localparam int          N_ROWS  = 14;
	localparam logic [31:0] ST_MASK = 32'h0000019F;

	ldc_row_type rows [N_ROWS] = '{
		'{32'h00000002, 3'h1, 32'h000, 3'h0},
		'{32'h00000001, 3'h0, 32'h00D, 3'h2},
		'{32'h00000002, 3'h0, 32'h00F, 3'h6},
		'{32'h00000003, 3'h0, 32'h00D, 3'h2},
		'{32'h00000002, 3'h0, 32'h00F, 3'h6},
		'{32'h00000013, 3'h0, 32'h001, 3'h0},
		'{32'h00000013, 3'h2, 32'h001, 3'h0},
		'{32'h00000014, 3'h0, 32'h00D, 3'h2},
		'{32'h00000002, 3'h0, 32'h00F, 3'h6},
		'{32'h00001105, 3'h0, 32'h017, 3'h6},
		'{32'h00001105, 3'h2, 32'h017, 3'h6},
		'{32'h00010205, 3'h0, 32'h097, 3'h7},
		'{32'h00000305, 3'h0, 32'h00F, 3'h6},
		'{32'h00020205, 3'h3, 32'h00F, 3'h6}
	};

	// ======================================================
	// Signals
	logic                   clk_sys = 1'b0;
	logic                   reset_n = 1'b0;
	ldc_pkg::ldc_bus_type   bus     = '0;
	logic                   rtc_en  = 1'b0;
	logic                   rtc_running;
	logic                   rtc_tick;
	logic [31:0]            rdata_reg;
	ldc_pkg::ldc_panel_type panel_reg;
	logic                   irq_reg;
	int                     n_mismatch = 0;
	int                     n_tests    = 0;
	logic [31:0]            rv;
	logic                   sb;

	always #20 clk_sys = ~clk_sys;

	ldc_display_ctrl #(.WAIT_CYC(4)) DUT (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.bus         (bus),
		.rdata_reg   (rdata_reg),
		.rtc_running (rtc_running),
		.rtc_tick    (rtc_tick),
		.panel_reg   (panel_reg),
		.irq_reg     (irq_reg)
	);

	ldc_rtc_model #(.PERIOD(40), .WIDTH(4)) rtc (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.enable      (rtc_en),
		.rtc_running (rtc_running),
		.rtc_tick    (rtc_tick)
	);

	// ======================================================
	// Bus and compare tasks
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 d = rdata_reg;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
		n_tests++;
		if ((got & mask) !== (exp & mask)) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & mask, exp & mask);
		end
	endtask

	task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ======================================================
	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#(40 * 3000);
		n_mismatch++;
		end_of_test();
	end

	// ======================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		bus_rd(ldc_pkg::OFF_STATE, rv);
		chk_reg(rv, 32'h0, 32'hFFFFFFFF);
		bus_rd(ldc_pkg::OFF_IRQ_STATUS, rv);
		chk_reg(rv, 32'h0, 32'hFFFFFFFF);
		bus_rd(8'h20, rv);
		chk_reg(rv, 32'h0, 32'hFFFFFFFF);
		chk_pin(panel_reg, 7'h00);
		chk_pin({6'h0, irq_reg}, 7'h00);
		bus_wr(ldc_pkg::OFF_SEG_DATA, 32'h0000006B);
		bus_wr(ldc_pkg::OFF_CFG, 32'h00000001);
		// Table rows: refusals, both off variants, halt, restore, method and area changes
		for (int i = 0; i < N_ROWS; i++) begin
			bus_wr(ldc_pkg::OFF_CMD, rows[i].cmd);
			bus_rd(ldc_pkg::OFF_ERR, rv);
			chk_reg(rv, {29'h0, rows[i].err}, 32'h7);
			bus_rd(ldc_pkg::OFF_STATE, rv);
			chk_reg(rv, rows[i].state, ST_MASK);
			chk_pin({4'h0, panel_reg.drive_on, panel_reg.circuit_on, panel_reg.show_b}, {4'h0, rows[i].pan});
		end
		chk_pin(panel_reg, 7'h6B);

		// Interrupt: done and error pending, then enable, clear
		bus_rd(ldc_pkg::OFF_IRQ_STATUS, rv);
		chk_reg(rv, 32'h3, 32'h7);
		bus_wr(ldc_pkg::OFF_IRQ_ENABLE, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1 chk_pin({6'h0, irq_reg}, 7'h01);
		bus_wr(ldc_pkg::OFF_IRQ_CLEAR, 32'h2);
		repeat (2) @(posedge clk_sys);
		#1 chk_pin({6'h0, irq_reg}, 7'h00);
		bus_rd(ldc_pkg::OFF_IRQ_ENABLE, rv);
		chk_reg(rv, 32'h2, 32'h7);
		bus_wr(ldc_pkg::OFF_IRQ_CLEAR, 32'h1);
		bus_rd(ldc_pkg::OFF_IRQ_STATUS, rv);
		chk_reg(rv, 32'h0, 32'h7);

		// Blinking with the clock running
		@(posedge clk_sys);
		rtc_en <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus_wr(ldc_pkg::OFF_CMD, 32'h00020205);
		bus_rd(ldc_pkg::OFF_ERR, rv);
		chk_reg(rv, 32'h0, 32'h7);
		bus_rd(ldc_pkg::OFF_STATE, rv);
		chk_reg(rv, 32'h10F, ST_MASK);
		for (int k = 0; k < 3; k++) begin
			@(posedge rtc_tick);
			sb = panel_reg.show_b;
			repeat (8) @(posedge clk_sys);
			#1 chk_pin(panel_reg, sb ? 7'h6B : 7'h76);
		end

		// Device-timed boost wait after reopening with self wait chosen
		bus_wr(ldc_pkg::OFF_CMD, 32'h00000013);
		bus_wr(ldc_pkg::OFF_CMD, 32'h00000006);
		bus_wr(ldc_pkg::OFF_CFG, 32'h00000005);
		bus_wr(ldc_pkg::OFF_CMD, 32'h00000001);
		bus_wr(ldc_pkg::OFF_CMD, 32'h00000013);
		bus_wr(ldc_pkg::OFF_CMD, 32'h00000014);
		bus_rd(ldc_pkg::OFF_STATE, rv);
		chk_reg(rv, 32'h404, 32'h404);
		repeat (10) @(posedge clk_sys);
		bus_rd(ldc_pkg::OFF_STATE, rv);
		chk_reg(rv, 32'h004, 32'h404);
		bus_rd(ldc_pkg::OFF_IRQ_STATUS, rv);
		chk_reg(rv, 32'h4, 32'h4);

		// Second reset in mid-run
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		bus_rd(ldc_pkg::OFF_STATE, rv);
		chk_reg(rv, 32'h0, 32'hFFFFFFFF);
		chk_pin(panel_reg, 7'h00);
		end_of_test();
	end
endmodule
